// ### sequencer_timing.sv
// sequencer register set, character timing and plane selection
`timescale 1ns/1ps
module sequencer_timing #(
  parameter logic [7:0] H_TOTAL = sequencer_pkg::H_TOTAL_DEFAULT,
  parameter logic [7:0] H_DISPLAY = sequencer_pkg::H_DISPLAY_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic ioDataPort,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata,
  input wire logic [7:0] extRdata,
  output logic extWrite,
  output logic [7:0] extIndex,
  output logic [7:0] extWdata,
  input wire logic [1:0] hostAddr,
  input wire logic [1:0] readMapSelect,
  input wire logic gfxOddEven,
  output logic [3:0] writePlanes,
  output logic [1:0] readPlane,
  output logic memLimit64k,
  input wire logic rowStart,
  input wire logic attrBit3,
  output logic [2:0] fontBank,
  output logic fontSwitchOn,
  output logic dotClkEn,
  output logic charClkEn,
  output logic serialLoad,
  output logic [7:0] hCount,
  output logic displayEnableFlag,
  output logic videoBlank
);
  import sequencer_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] index;
    logic [1:0] syncRst;
    logic [7:0] clkMode;
    logic [3:0] planeMask;
    logic [5:0] fontSel;
    logic [5:0] fontLive;
    logic [7:0] memOrg;
    logic extEn;
    logic hold;
    logic [7:0] rdata;
    logic extWr;
    logic [7:0] extWd;
    logic phase;
    logic dotEn;
    logic [3:0] dotCnt;
    logic charEn;
    logic [1:0] loadCnt;
    logic loadEn;
    logic [7:0] hCnt;
    logic dispEn;
    logic blank;
    logic [3:0] wrPlanes;
    logic [1:0] rdPlane;
    logic [2:0] bank;
    logic fontSw;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic run;
  logic isExt;
  logic dataWr;
  logic [1:0] loadMask;
  logic [3:0] dotLast;

  // bank number from a font selection, bits 3,2,5 or 1,0,4
  function automatic logic [2:0] bankOf(input logic [5:0] sel, input logic secondary);
    bankOf = secondary ? {sel[3], sel[2], sel[5]} : {sel[1], sel[0], sel[4]};
  endfunction

  // address-derived plane select, before the mask
  function automatic logic [3:0] planeSel(input logic [1:0] a, input logic [7:0] mo);
    if (mo[MEM_CHAIN_FOUR]) begin
      planeSel = 4'h1 << a;
    end else if (!mo[MEM_ODD_EVEN_OFF]) begin
      planeSel = a[0] ? 4'hA : 4'h5;
    end else begin
      planeSel = 4'hF;
    end
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // one process owns all decisions; host writes first, then timing
  always_comb begin
    s_d = s_q;
    run = &s_q.syncRst;
    isExt = s_q.index[IDX_EXT_SELECT_BIT] && s_q.extEn;
    dataWr = ioWrite && ioDataPort && !isExt;
    loadMask = s_q.clkMode[CLK_SHIFT_FOUR] ? 2'h3 : {1'b0, s_q.clkMode[CLK_SHIFT_LOAD]};
    dotLast = s_q.clkMode[CLK_EIGHT_DOT] ? DOTS_EIGHT_LAST : DOTS_NINE_LAST;
    s_d.extWr = 1'b0;
    // host register writes
    if (ioWrite && !ioDataPort) begin
      s_d.index = ioWdata;
    end
    if (ioWrite && ioDataPort && isExt) begin
      s_d.extWr = 1'b1;
      s_d.extWd = ioWdata;
    end
    if (dataWr) begin
      unique case (s_q.index[2:0])
        IDX_SYNC_RESET: begin
          s_d.syncRst = ioWdata[1:0] & MASK_SYNC_RESET[1:0];
          // falling first reset bit (bit 0) clears the font selection
          if (s_q.syncRst[0] && !ioWdata[0]) begin
            s_d.fontSel = 6'h00;
          end
        end
        IDX_CLOCKING_MODE: s_d.clkMode = ioWdata & MASK_CLOCKING_MODE;
        IDX_PLANE_WRITE_MASK: s_d.planeMask = ioWdata[3:0] & MASK_PLANE_WRITE[3:0];
        IDX_FONT_BANK_SELECT: s_d.fontSel = ioWdata[5:0] & MASK_FONT_BANK[5:0];
        IDX_MEMORY_ORGANISATION: s_d.memOrg = ioWdata & MASK_MEMORY_ORG;
        IDX_EXTENSION_UNLOCK: begin
          s_d.hold = 1'b0;
          if (ioWdata == UNLOCK_ENABLE) begin
            s_d.extEn = 1'b1;
          end else if (ioWdata == UNLOCK_DISABLE) begin
            s_d.extEn = 1'b0;
          end
        end
        IDX_CHAR_COUNTER_HOLD: s_d.hold = 1'b1;
        default: begin
        end
      endcase
    end
    // host reads, answered one cycle later
    if (ioRead && !ioDataPort) begin
      s_d.rdata = isExt ? s_q.index : {5'h00, s_q.index[2:0]};
    end else if (ioRead && isExt) begin
      s_d.rdata = extRdata;
    end else if (ioRead) begin
      unique case (s_q.index[2:0])
        IDX_SYNC_RESET: s_d.rdata = {6'h00, s_q.syncRst};
        IDX_CLOCKING_MODE: s_d.rdata = s_q.clkMode;
        IDX_PLANE_WRITE_MASK: s_d.rdata = {4'h0, s_q.planeMask};
        IDX_FONT_BANK_SELECT: s_d.rdata = {2'h0, s_q.fontSel};
        IDX_MEMORY_ORGANISATION: s_d.rdata = s_q.memOrg;
        IDX_EXTENSION_UNLOCK: s_d.rdata = {7'h00, s_q.extEn};
        default: s_d.rdata = RESET_VALUE;
      endcase
    end
    // dot and character clocks, frozen while halted
    s_d.phase = run ? !s_q.phase : 1'b0;
    s_d.dotEn = run && (!s_q.clkMode[CLK_DOT_DIV] || s_q.phase);
    s_d.charEn = run && s_q.dotEn && (s_q.dotCnt >= dotLast);
    if (run && s_q.dotEn) begin
      s_d.dotCnt = (s_q.dotCnt >= dotLast) ? 4'h0 : s_q.dotCnt + 4'h1;
    end
    // serializer load cadence; screen off suppresses the load only
    s_d.loadEn = 1'b0;
    if (run && s_q.charEn) begin
      s_d.loadCnt = (s_q.loadCnt & loadMask) == loadMask ? 2'h0 : s_q.loadCnt + 2'h1;
      s_d.loadEn = ((s_q.loadCnt & loadMask) == loadMask) && !s_q.clkMode[CLK_SCREEN_OFF];
    end
    // horizontal counter; display enable ignores screen off
    if (s_d.hold) begin
      s_d.hCnt = 8'h00;
    end else if (run && s_q.charEn) begin
      s_d.hCnt = (s_q.hCnt >= H_TOTAL - 8'h01) ? 8'h00 : s_q.hCnt + 8'h01;
    end
    s_d.dispEn = s_q.hCnt < H_DISPLAY;
    s_d.blank = s_q.clkMode[CLK_SCREEN_OFF] || !s_q.dispEn || !run;
    // font bank latched at row start so a change never tears a row
    if (rowStart) begin
      s_d.fontLive = s_q.fontSel;
    end
    s_d.fontSw = bankOf(s_q.fontLive, 1'b0) != bankOf(s_q.fontLive, 1'b1);
    s_d.bank = bankOf(s_q.fontLive, s_q.fontSw && attrBit3);
    // host plane steering
    s_d.wrPlanes = s_q.planeMask & planeSel(hostAddr, s_q.memOrg);
    if (s_q.memOrg[MEM_CHAIN_FOUR]) begin
      s_d.rdPlane = hostAddr;
    end else if (!s_q.memOrg[MEM_ODD_EVEN_OFF] || gfxOddEven) begin
      s_d.rdPlane = {readMapSelect[1], hostAddr[0]};
    end else begin
      s_d.rdPlane = readMapSelect;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // clock enable low freezes every field, strobes included
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign ioRdata = s_q.rdata;
  assign extWrite = s_q.extWr;
  assign extIndex = s_q.index;
  assign extWdata = s_q.extWd;
  assign writePlanes = s_q.wrPlanes;
  assign readPlane = s_q.rdPlane;
  assign memLimit64k = !s_q.memOrg[MEM_EXTENDED];
  assign fontBank = s_q.bank;
  assign fontSwitchOn = s_q.fontSw;
  assign dotClkEn = s_q.dotEn;
  assign charClkEn = s_q.charEn;
  assign serialLoad = s_q.loadEn;
  assign hCount = s_q.hCnt;
  assign displayEnableFlag = s_q.dispEn;
  assign videoBlank = s_q.blank;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic unlockWr;
  assign unlockWr = clkEn && dataWr && s_q.index[2:0] == IDX_EXTENSION_UNLOCK;

  a_screen_off_load: assert property (s_q.clkMode[CLK_SCREEN_OFF] && $past(s_q.clkMode[CLK_SCREEN_OFF])
    |-> !s_q.loadEn) else $error("load while screen off");
  a_screen_off_blank: assert property (clkEn && s_q.clkMode[CLK_SCREEN_OFF] |=> s_q.blank)
    else $error("no blank while screen off");
  a_dot_half: assert property (clkEn && run && s_q.clkMode[CLK_DOT_DIV] && s_q.dotEn
    |=> !s_q.dotEn) else $error("dot clock not halved");
  a_plane_and: assert property (clkEn |=> s_q.wrPlanes ==
    ($past(s_q.planeMask) & planeSel($past(hostAddr), $past(s_q.memOrg))))
    else $error("write planes wrong");
  a_unlock_on: assert property (unlockWr && ioWdata == UNLOCK_ENABLE |=> s_q.extEn && !s_q.hold)
    else $error("unlock failed");
  a_unlock_off: assert property (unlockWr && ioWdata == UNLOCK_DISABLE |=> !s_q.extEn)
    else $error("lock failed");
  a_hold_zero: assert property (clkEn && dataWr && s_q.index[2:0] == IDX_CHAR_COUNTER_HOLD
    |=> s_q.hold && s_q.hCnt == 8'h00) else $error("hold not applied");
  a_halt_freeze: assert property (clkEn && !run |=> !s_q.dotEn && !s_q.charEn && !s_q.loadEn)
    else $error("timing ran while halted");
  a_ext_gate: assert property (s_q.extWr |-> $past(s_q.extEn) && $past(s_q.index[IDX_EXT_SELECT_BIT]))
    else $error("extension write while locked");
  a_font_row: assert property (clkEn && !rowStart |=> $stable(s_q.fontLive))
    else $error("font changed mid row");

  c_unlock: cover property (unlockWr && ioWdata == UNLOCK_ENABLE);
  c_load_four: cover property (s_q.loadEn && s_q.clkMode[CLK_SHIFT_FOUR]);
  c_font_switch: cover property (s_q.fontSw && attrBit3);
  c_chain_four: cover property (s_q.memOrg[MEM_CHAIN_FOUR] && s_q.wrPlanes != 4'h0);
endmodule

// ### sequencer_pkg.sv
// constants shared by the sequencer register block
package sequencer_pkg;
  // ---------------------------------------------------------------
  // register indices behind the data port
  // ---------------------------------------------------------------
  localparam logic [2:0] IDX_SYNC_RESET = 3'h0;
  localparam logic [2:0] IDX_CLOCKING_MODE = 3'h1;
  localparam logic [2:0] IDX_PLANE_WRITE_MASK = 3'h2;
  localparam logic [2:0] IDX_FONT_BANK_SELECT = 3'h3;
  localparam logic [2:0] IDX_MEMORY_ORGANISATION = 3'h4;
  localparam logic [2:0] IDX_EXTENSION_UNLOCK = 3'h6;
  localparam logic [2:0] IDX_CHAR_COUNTER_HOLD = 3'h7;
  localparam int IDX_EXT_SELECT_BIT = 7;
  // ---------------------------------------------------------------
  // field positions and writable masks
  // ---------------------------------------------------------------
  localparam int CLK_SCREEN_OFF = 5;
  localparam int CLK_SHIFT_FOUR = 4;
  localparam int CLK_DOT_DIV = 3;
  localparam int CLK_SHIFT_LOAD = 2;
  localparam int CLK_EIGHT_DOT = 0;
  localparam int MEM_CHAIN_FOUR = 3;
  localparam int MEM_ODD_EVEN_OFF = 2;
  localparam int MEM_EXTENDED = 1;
  localparam logic [7:0] MASK_SYNC_RESET = 8'h03;
  localparam logic [7:0] MASK_CLOCKING_MODE = 8'h3D;
  localparam logic [7:0] MASK_PLANE_WRITE = 8'h0F;
  localparam logic [7:0] MASK_FONT_BANK = 8'h3F;
  localparam logic [7:0] MASK_MEMORY_ORG = 8'h0E;
  // ---------------------------------------------------------------
  // unlock codes, reset values, timing counts
  // ---------------------------------------------------------------
  localparam logic [7:0] UNLOCK_ENABLE = 8'hEA;
  localparam logic [7:0] UNLOCK_DISABLE = 8'hAE;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [3:0] DOTS_NINE_LAST = 4'h8;
  localparam logic [3:0] DOTS_EIGHT_LAST = 4'h7;
  localparam logic [7:0] H_TOTAL_DEFAULT = 8'h64;
  localparam logic [7:0] H_DISPLAY_DEFAULT = 8'h50;
endpackage

// ### host_model.sv
// host processor model driving the sequencer index and data ports
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  output logic ioWrite,
  output logic ioRead,
  output logic ioDataPort,
  output logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata
);
  // idle bus, data inverted once released so stale values never match
  initial begin
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioDataPort = 1'b0;
    ioWdata = 8'h00;
  end
  task automatic wr(input logic port, input logic [7:0] d);
    @(posedge clock);
    #1;
    ioWrite = 1'b1;
    ioDataPort = port;
    ioWdata = d;
    @(posedge clock);
    #1;
    ioWrite = 1'b0;
    ioWdata = ~d;
  endtask
  task automatic rd(input logic port, output logic [7:0] d);
    @(posedge clock);
    #1;
    ioRead = 1'b1;
    ioDataPort = port;
    @(posedge clock);
    #1;
    ioRead = 1'b0;
    d = ioRdata;
  endtask
  task automatic setreg(input logic [7:0] idx, input logic [7:0] d);
    wr(1'b0, idx);
    wr(1'b1, d);
  endtask
  // timing registers only change with the sequencer halted
  task automatic retime(input logic [7:0] idx, input logic [7:0] d);
    setreg(8'h00, 8'h00);
    setreg(idx, d);
    setreg(8'h00, 8'h03);
  endtask
endmodule

// ### sequencer_timing_and_plane_control_test.sv
// self-checking bench for the sequencer register block
`timescale 1ns/1ps
module sequencer_timing_and_plane_control_test;
  import sequencer_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ioWrite, ioRead, ioDataPort, extWrite, memLimit64k, rowStart = 1'b0, attrBit3 = 1'b0;
  logic fontSwitchOn, dotClkEn, charClkEn, serialLoad, displayEnableFlag, videoBlank;
  logic [7:0] ioWdata, ioRdata, extIndex, extWdata, hCount, rv, v, extRdata = 8'h00;
  logic [1:0] hostAddr = 2'h0, readPlane;
  logic [3:0] writePlanes;
  logic [2:0] fontBank;
  logic [31:0] lfsrQ = 32'hd062_0798;
  int mismatches = 0, cmp_count = 0, extCnt = 0, n, k, t, dc;
  logic [7:0] mdl [8];
  logic [7:0] cms [6] = '{8'h00, 8'h01, 8'h08, 8'h04, 8'h10, 8'h14};
  logic [7:0] msk [5] = '{MASK_SYNC_RESET, MASK_CLOCKING_MODE, MASK_PLANE_WRITE, MASK_FONT_BANK, MASK_MEMORY_ORG};
  always #4 clock = ~clock;
  always @(posedge clock) if (extWrite === 1'b1) extCnt++;
  host_model host_u (.clock(clock), .ioWrite(ioWrite), .ioRead(ioRead), .ioDataPort(ioDataPort),
    .ioWdata(ioWdata), .ioRdata(ioRdata));
  sequencer_timing #(.H_TOTAL(8'h0A), .H_DISPLAY(8'h06)) dut_u (.clock(clock), .rst_n(rst_n), .clkEn(1'b1),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioDataPort(ioDataPort), .ioWdata(ioWdata), .ioRdata(ioRdata),
    .extRdata(extRdata), .extWrite(extWrite), .extIndex(extIndex), .extWdata(extWdata), .hostAddr(hostAddr),
    .readMapSelect(2'h0), .gfxOddEven(1'b0), .writePlanes(writePlanes), .readPlane(readPlane),
    .memLimit64k(memLimit64k), .rowStart(rowStart), .attrBit3(attrBit3), .fontBank(fontBank),
    .fontSwitchOn(fontSwitchOn), .dotClkEn(dotClkEn), .charClkEn(charClkEn), .serialLoad(serialLoad),
    .hCount(hCount), .displayEnableFlag(displayEnableFlag), .videoBlank(videoBlank));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr();
    lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
    return lfsrQ[7:0];
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  // cycles between two pulses of charClkEn (s=0) or serialLoad (s=1); bounded
  task automatic gap(input int s, output int c);
    k = 0;
    while ((s ? serialLoad : charClkEn) !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    c = 0;
    do begin
      tick(1);
      c++;
    end while ((s ? serialLoad : charClkEn) !== 1'b1 && c < 400);
    if (k >= 400 || c >= 400) begin
      mismatches++;
      finish_test();
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    host_u.setreg(IDX_EXTENSION_UNLOCK, 8'h00);
    host_u.rd(1'b1, rv);
    chk(rv, 8'h00);
    for (int i = 1; i < 5; i++) begin
      v = lfsr();
      mdl[i] = v & msk[i];
      host_u.setreg(i[7:0], v);
      host_u.rd(1'b1, rv);
      chk(rv, mdl[i]);
    end
    host_u.setreg(8'h85, lfsr());
    host_u.rd(1'b1, rv);
    chk(rv, 8'h00);
    host_u.rd(1'b0, rv);
    chk(rv, 8'h05);
    $display("registers done");
    // latch the selection written above so the first old-bank check has a defined base
    rowStart = 1'b1;
    tick(1);
    rowStart = 1'b0;
    for (int i = 0; i < 4; i++) begin
      v = lfsr();
      host_u.setreg(IDX_FONT_BANK_SELECT, v);
      attrBit3 = i[0];
      tick(3);
      chk({5'h0, fontBank}, {5'h0, attrBit3 ? {mdl[3][3:2], mdl[3][5]} : {mdl[3][1:0], mdl[3][4]}});
      mdl[3] = v & MASK_FONT_BANK;
      rowStart = 1'b1;
      tick(1);
      rowStart = 1'b0;
      tick(2);
      chk({5'h0, fontBank}, {5'h0, attrBit3 ? {v[3:2], v[5]} : {v[1:0], v[4]}});
      chk({7'h0, fontSwitchOn}, {7'h0, {v[3:2], v[5]} != {v[1:0], v[4]}});
    end
    $display("font done");
    host_u.setreg(IDX_EXTENSION_UNLOCK, UNLOCK_ENABLE);
    host_u.rd(1'b1, rv);
    chk(rv, 8'h01);
    extRdata = lfsr();
    v = lfsr();
    n = extCnt;
    host_u.setreg(8'h9C, v);
    host_u.rd(1'b1, rv);
    chk(rv, extRdata);
    chk(extWdata, v);
    chk(extIndex, 8'h9C);
    chk(8'(extCnt - n), 8'h01);
    host_u.rd(1'b0, rv);
    chk(rv, 8'h9C);
    host_u.setreg(IDX_EXTENSION_UNLOCK, UNLOCK_DISABLE);
    host_u.rd(1'b1, rv);
    chk(rv, 8'h00);
    n = extCnt;
    host_u.setreg(8'h9C, v);
    chk(8'(extCnt - n), 8'h00);
    $display("extension done");
    v = lfsr();
    host_u.setreg(IDX_PLANE_WRITE_MASK, v);
    for (int mo = 0; mo < 16; mo += 2) begin
      host_u.retime(IDX_MEMORY_ORGANISATION, mo[7:0]);
      chk({7'h0, memLimit64k}, {7'h0, !mo[1]});
      for (int a = 0; a < 4; a++) begin
        hostAddr = a[1:0];
        tick(2);
        chk({4'h0, writePlanes}, {4'h0, v[3:0] & (mo[3] ? 4'(1 << a) : (mo[2] ? 4'hF : (a[0] ? 4'hA : 4'h5)))});
        chk({6'h0, readPlane}, {6'h0, mo[3] ? a[1:0] : (mo[2] ? 2'h0 : {1'b0, a[0]})});
      end
    end
    $display("planes done");
    for (int i = 0; i < 6; i++) begin
      host_u.retime(IDX_CLOCKING_MODE, cms[i]);
      t = (cms[i][0] ? 8 : 9) * (cms[i][3] ? 2 : 1);
      gap(0, n);
      chk(8'(n), 8'(t));
      gap(1, n);
      chk(8'(n), 8'(t * (cms[i][4] ? 4 : (cms[i][2] ? 2 : 1))));
    end
    host_u.retime(IDX_CLOCKING_MODE, 8'h20);
    n = 0;
    k = 0;
    v = 8'h01;
    t = 0;
    dc = 0;
    for (int i = 0; i < 300; i++) begin
      tick(1);
      n += (serialLoad !== 1'b0);
      k += (displayEnableFlag !== v[0]);
      v = {7'h0, displayEnableFlag};
      t += (videoBlank !== 1'b1);
      dc += (dotClkEn === 1'b1);
    end
    chk(8'(n), 8'h00);
    chk(8'(t), 8'h00);
    chk(8'(dc), 8'(300));
    chk({7'h0, k > 1}, 8'h01);
    $display("timing done");
    host_u.retime(IDX_CLOCKING_MODE, 8'h00);
    host_u.setreg(IDX_CHAR_COUNTER_HOLD, lfsr());
    n = 0;
    for (int i = 0; i < 100; i++) begin
      tick(1);
      n += (hCount !== 8'h00);
    end
    chk(8'(n), 8'h00);
    host_u.setreg(IDX_EXTENSION_UNLOCK, 8'h00);
    n = 0;
    for (int i = 0; i < 100; i++) begin
      tick(1);
      n += (hCount !== 8'h00);
    end
    chk({7'h0, n > 0}, 8'h01);
    $display("hold done");
    finish_test();
  end
endmodule
